/* design/drs_pkg.sv */
// Summary of operation
// - after moving to 2x or 4x rate old postponements honoured while shrinking
// - controller may refresh at reported or faster rate, using that rate's limits
// - each channel keeps its refresh state independently
// - abort supported from 6Gb per channel; delay is one-bank cycle plus 17.5 ns
// - abort enable aborts ongoing refresh at exit, counter not advanced
package drs_pkg;
  localparam int          CLK_PERIOD_PS       = 5000;
  localparam int          REFI_NS_X1000       = 3904000;
  localparam int          REFI_PB_NS          = 488;
  localparam int          REFRESHES_PER_WIN   = 8192;
  localparam int          ABORT_EXTRA_PS      = 17500;
  localparam int          RFCPB_PS            = 90000;
  localparam int          REFI_CYC = REFI_NS_X1000 / CLK_PERIOD_PS;
  localparam int          ABORT_CYC = (RFCPB_PS + ABORT_EXTRA_PS + CLK_PERIOD_PS - 1)
                                      / CLK_PERIOD_PS;
  localparam int          NBANKS              = 8;
  localparam int          ABORT_BIT           = 3;
  localparam int          MIN_ABORT_GB        = 6;
  localparam logic [2:0]  CODE_LOW            = 3'h0;
  localparam logic [2:0]  CODE_4X             = 3'h1;
  localparam logic [2:0]  CODE_2X             = 3'h2;
  localparam logic [2:0]  CODE_HIGH           = 3'h7;
  localparam logic [7:0]  LIM_4X              = 8'h10;
  localparam logic [7:0]  LIM_2X              = 8'h20;
  localparam logic [7:0]  LIM_STD             = 8'h40;
  typedef struct packed {
    logic       ref_all;
    logic       ref_one;
    logic [2:0] bank;
    logic       sr_entry;
    logic       sr_exit;
  } drs_cmd_s;
  typedef enum logic [1:0] {DRS_ACTIVE, DRS_SELF, DRS_ABORT} drs_mode_e;
endpackage : drs_pkg

/* design/drs_abort_timer.sv */
module drs_abort_timer #(
  parameter int CYC = drs_pkg::ABORT_CYC
) (
  // clocking
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  // control
  input  wire logic start,
  output logic      busy
);
  initial if (CYC < 1) $error("abort delay must be positive");
  logic [15:0] cnt_r, cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    if (start) cnt_nxt = 16'(CYC);
    else if (cnt_r != 16'h0) cnt_nxt = cnt_r - 16'h1;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) cnt_r <= 16'h0;
    else if (ce) cnt_r <= cnt_nxt;
  end
  assign busy = (cnt_r != 16'h0);
endmodule : drs_abort_timer

/* design/drs_refresh_scheduler.sv */
module drs_refresh_scheduler #(
  parameter int DENSITY_GB = 8,
  parameter int REFI_CYC   = drs_pkg::REFI_CYC
) (
  // clocking
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic            ce,
  // command input, same clock domain
  input  wire drs_pkg::drs_cmd_s cmd,
  input  wire logic [3:0]      thermal_rate_register,
  // status
  output logic [7:0]           postpone_cnt,
  output logic                 extra_ref_done,
  output logic                 self_refresh,
  output logic                 cmd_blocked,
  output logic [12:0]          internal_row
);
  initial if (REFI_CYC < 2 || DENSITY_GB < 1) $error("bad parameters");
  localparam logic abort_ok = (DENSITY_GB >= drs_pkg::MIN_ABORT_GB);

  drs_pkg::drs_mode_e mode_r, mode_nxt;
  logic signed [8:0]  debt_r, debt_nxt;   // eighths owed, this channel only
  logic [31:0]        tick_r, tick_nxt;
  logic               extra_r, extra_nxt;
  logic [12:0]        row_r, row_nxt;
  logic [2:0]         code_r;
  logic               blk_r, blk_nxt;
  logic               abort_busy;
  logic               is_ref;
  logic [7:0]         lim;
  logic               nolim;
  logic [3:0]         inc;

  // limit follows the reported code; 4x and 2x codes carry smaller limits than the standard one
  always_comb begin
    // temperature-limit codes carry no slack limit; refresh is refused there only during abort
    nolim = (thermal_rate_register[2:0] == drs_pkg::CODE_LOW) ||
            (thermal_rate_register[2:0] == drs_pkg::CODE_HIGH);
    case (thermal_rate_register[2:0])
      drs_pkg::CODE_4X: lim = drs_pkg::LIM_4X;
      drs_pkg::CODE_2X: lim = drs_pkg::LIM_2X;
      default:          lim = drs_pkg::LIM_STD;
    endcase
  end

  always_comb begin
    is_ref   = cmd.ref_all | cmd.ref_one;
    inc      = cmd.ref_all ? 4'h8 : 4'h1;
    mode_nxt = mode_r;
    debt_nxt = debt_r;
    tick_nxt = tick_r + 32'h1;
    extra_nxt = extra_r;
    row_nxt  = row_r;
    blk_nxt  = 1'b0;
    if (tick_r == 32'(REFI_CYC - 1)) begin
      tick_nxt = 32'h0;
      if (mode_r == drs_pkg::DRS_ACTIVE) debt_nxt = debt_r + 9'sd8;
    end
    // pulled-in credit dropped on phase change; postponed debt is kept
    if (thermal_rate_register[2:0] != code_r && debt_nxt < 0) debt_nxt = '0;
    case (mode_r)
      drs_pkg::DRS_ACTIVE: begin
        if (is_ref) begin
          if (!extra_r) extra_nxt = 1'b1;
          else if (debt_nxt > -$signed({1'b0, lim})) debt_nxt = debt_nxt - $signed({5'h0, inc});
          else if (!nolim) blk_nxt = 1'b1;
          row_nxt = row_r + 13'h1;
        end
        if (cmd.sr_entry) mode_nxt = drs_pkg::DRS_SELF;
      end
      drs_pkg::DRS_SELF: begin
        if (cmd.sr_exit) begin
          extra_nxt = 1'b0;
          if (thermal_rate_register[drs_pkg::ABORT_BIT] && abort_ok)
            mode_nxt = drs_pkg::DRS_ABORT;
          else
            mode_nxt = drs_pkg::DRS_ACTIVE;
        end else if (tick_r == 32'(REFI_CYC - 1)) row_nxt = row_r + 13'h1;
      end
      drs_pkg::DRS_ABORT: begin
        if (!abort_busy) mode_nxt = drs_pkg::DRS_ACTIVE;
        if (is_ref || cmd.sr_entry) blk_nxt = 1'b1;
      end
      default: mode_nxt = drs_pkg::DRS_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r  <= drs_pkg::DRS_ACTIVE;
      debt_r  <= '0;
      tick_r  <= 32'h0;
      extra_r <= 1'b1;
      row_r   <= 13'h0;
      code_r  <= drs_pkg::CODE_LOW;
      blk_r   <= 1'b0;
    end else if (ce) begin
      mode_r  <= mode_nxt;
      debt_r  <= debt_nxt;
      tick_r  <= tick_nxt;
      extra_r <= extra_nxt;
      row_r   <= row_nxt;
      code_r  <= thermal_rate_register[2:0];
      blk_r   <= blk_nxt;
    end
  end

  drs_abort_timer #(.CYC(drs_pkg::ABORT_CYC)) u_abort (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .start   (mode_r == drs_pkg::DRS_SELF && cmd.sr_exit && mode_nxt == drs_pkg::DRS_ABORT),
    .busy    (abort_busy)
  );

  // outputs straight from flops; debt shown clipped at zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      postpone_cnt   <= 8'h0;
      extra_ref_done <= 1'b1;
      self_refresh   <= 1'b0;
      cmd_blocked    <= 1'b0;
      internal_row   <= 13'h0;
    end else if (ce) begin
      postpone_cnt   <= debt_nxt > 0 ? debt_nxt[7:0] : 8'h0;
      extra_ref_done <= extra_nxt;
      self_refresh   <= (mode_nxt == drs_pkg::DRS_SELF);
      cmd_blocked    <= blk_nxt;
      internal_row   <= row_nxt;
    end
  end

  property p_abort_holds;
    @(posedge clk) disable iff (sys_rst)
    (ce && mode_r == drs_pkg::DRS_SELF && cmd.sr_exit && mode_nxt == drs_pkg::DRS_ABORT)
      |=> mode_r == drs_pkg::DRS_ABORT;
  endproperty
  a_abort_holds: assert property (p_abort_holds) else $error("abort not entered");
  property p_abort_refuses;
    @(posedge clk) disable iff (sys_rst)
    (ce && mode_r == drs_pkg::DRS_ABORT && is_ref) |=> cmd_blocked;
  endproperty
  a_abort_refuses: assert property (p_abort_refuses) else $error("refresh taken in abort");
  property p_row_frozen;
    @(posedge clk) disable iff (sys_rst)
    (mode_r == drs_pkg::DRS_ABORT && !is_ref) |=> $stable(row_r);
  endproperty
  a_row_frozen: assert property (p_row_frozen) else $error("row moved in abort");
  property p_extra;
    @(posedge clk) disable iff (sys_rst)
    (ce && mode_r == drs_pkg::DRS_SELF && cmd.sr_exit) |=> !extra_r;
  endproperty
  a_extra: assert property (p_extra) else $error("extra flag not cleared");
  property p_limit;
    @(posedge clk) disable iff (sys_rst) debt_r >= -9'sd72;
  endproperty
  a_limit: assert property (p_limit) else $error("pull-in beyond limit");
endmodule : drs_refresh_scheduler

/* tb/drs_ctrl_model.sv */
module drs_ctrl_model (
  // clocking
  input  wire logic          clk,
  // commands toward the scheduler, one channel only
  output drs_pkg::drs_cmd_s  cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cmd = '0;
  // no reads are issued, so read-to-refresh gaps hold trivially
  // kind 0 all-bank, 1 one-bank, 2 entry, 3 exit; held one full cycle around a rising edge
  task automatic issue(input int kind, input logic [2:0] bank);
    @(negedge clk);
    cmd          = '0;
    cmd.ref_all  = (kind == 0);
    cmd.ref_one  = (kind == 1);
    cmd.bank     = bank;
    cmd.sr_entry = (kind == 2);
    cmd.sr_exit  = (kind == 3);
    @(negedge clk);
    cmd = '0;
  endtask : issue
endmodule : drs_ctrl_model

/* tb/tb_dram_refresh_scheduler.sv */
module tb_dram_refresh_scheduler;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int     RC = 400;
  logic              clk = 0, sys_rst = 1, ce = 1;
  logic [3:0]        trr = 4'h3;
  logic [12:0]       row, r;
  logic [7:0]        pc;
  logic              xd, sr, blk;
  drs_pkg::drs_cmd_s cmd;
  int                fails = 0, checked = 0, nblk = 0, cyc = 0, seed = 32'h07c15c5b;
  int                n, c, i;
  drs_ctrl_model m (.clk(clk), .cmd(cmd));
  drs_refresh_scheduler #(.DENSITY_GB(8), .REFI_CYC(RC)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .ce(ce), .cmd(cmd), .thermal_rate_register(trr), .postpone_cnt(pc),
    .extra_ref_done(xd), .self_refresh(sr), .cmd_blocked(blk), .internal_row(row));
  initial forever #2.5 clk = ~clk;
  // all-bank pull-in limit per rate code, zero where the code carries none
  function automatic int lim(input int code);
    case (code)
      1: return 2;
      2: return 4;
      0, 7: return 0;
      default: return 8;
    endcase
  endfunction : lim
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      $display("BAD %0t %s", $time, msg);
      fails++;
    end
  endtask : chk
  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic do_reset;
    sys_rst = 1;
    repeat (2) @(negedge clk);
    sys_rst = 0;
    nblk = 0;
  endtask : do_reset
  always @(posedge clk) begin
    if (blk === 1'b1) nblk++;
    cyc++;
    if (cyc > 20000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    do_reset();
    chk(pc === 8'h00 && xd === 1'b1 && sr === 1'b0 && blk === 1'b0, "reset values");
    chk(row === 13'h0000, "reset row");
    // burst of pull-ins per code, one-bank on odd codes, random banks
    for (c = 0; c < 8; c++) begin
      trr = c[3:0];
      do_reset();
      n = (lim(c) == 0) ? 10 : lim(c);
      for (i = 0; i < (c[0] ? 8 * n + 1 : n + 1); i++) m.issue(c[0], 3'($random(seed)));
      repeat (3) @(negedge clk);
      chk(nblk == ((lim(c) == 0) ? 0 : 1), "pull-in limit");
      chk(pc === 8'h00, "debt clipped");
    end
    // phase change restarts the pull-in count
    trr = 4'h3;
    do_reset();
    for (i = 0; i < 8; i++) m.issue(0, 3'h0);
    trr = 4'h4;
    for (i = 0; i < 9; i++) m.issue(0, 3'h0);
    repeat (3) @(negedge clk);
    chk(nblk == 1, "new phase credit");
    // debt accrues one all-bank per interval
    trr = 4'h3;
    do_reset();
    repeat (2 * RC + 5) @(negedge clk);
    chk(pc === 8'h10, "accrued debt");
    m.issue(0, 3'h0);
    chk(pc === 8'h08, "debt paid");
    // self refresh with abort enabled
    trr = 4'hb;
    do_reset();
    m.issue(2, 3'h0);
    chk(sr === 1'b1, "self refresh entered");
    r = row;
    m.issue(3, 3'h0);
    m.issue(1, 3'h2);
    repeat (drs_pkg::ABORT_CYC) @(negedge clk);
    chk(nblk == 1 && row === r, "abort delay");
    chk(xd === 1'b0, "extra refresh owed");
    m.issue(0, 3'h0);
    chk(xd === 1'b1 && pc === 8'h00 && nblk == 1, "extra refresh");
    close_out();
  end
endmodule : tb_dram_refresh_scheduler
